// ### logic/bsi_map.vh
`ifndef BSI_MAP_VH
`define BSI_MAP_VH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
// ==========================================================================
`define BSI_OFF_CTRL    4'h0
`define BSI_OFF_MODEM   4'h4
`define BSI_OFF_IRQST   4'h8

// ==========================================================================
// Control word field positions
// ==========================================================================
`define BSI_BIT_MCLR    4
`define BSI_BIT_RIE     6
`define BSI_BIT_RXDONE  7
`define BSI_BIT_SAE     12
`define BSI_BIT_TIE     14
`define BSI_BIT_TXRDY   15

// ==========================================================================
// Reset values
// ==========================================================================
`define BSI_RST_DTR     4'h0
`define BSI_RST_WORD    32'h0000_0000

// ==========================================================================
// Timing, in nanoseconds and in cycles of the core clock
// ==========================================================================
`define BSI_CLK_NS      8
`define BSI_MCLR_NS     2400
`define BSI_EXT_NS      300
// Counts are sized to the counter so a load never drops bits; the pulse is
// 2400 ns over 8 ns, and the stretch is 300 ns rounded down to whole cycles.
`define BSI_MCLR_CYC    9'h12C
`define BSI_EXT_CYC     9'h025
`define BSI_CNT_W       9

`endif

// ### logic/bsi_top.v
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bsi_map.vh"


module bsi_top
(
   input  wire        CORE_CLK_IN,
   input  wire        SYS_RST_IN,
   input  wire        CLK_EN_IN,
   input  wire [3:0]  AVS_ADDRESS_IN,
   input  wire        AVS_READ_IN,
   input  wire        AVS_WRITE_IN,
   input  wire [31:0] AVS_WRITEDATA_IN,
   input  wire [3:0]  AVS_BYTEENABLE_IN,
   output reg  [31:0] AVS_READDATA_OUT,
   output reg         AVS_WAITREQUEST_OUT,
   input  wire        CYCLE_SYNC_IN,
   input  wire        WRITE_DATA_STROBE_IN,
   input  wire        READ_DATA_STROBE_IN,
   input  wire        BYTE_WRITE_QUALIFIER_IN,
   input  wire        ADDRESS_MATCH_IN,
   input  wire [2:0]  ADDRESS_LOW_IN,
   input  wire        ACK_CHAIN_IN,
   input  wire        BUS_INITIALIZE_IN,
   input  wire        RX_DONE_IN,
   input  wire        SILO_ALARM_IN,
   input  wire        TX_READY_IN,
   input  wire [5:0]  VECTOR_SWITCH_IN,
   output reg         SLAVE_REPLY_OUT,
   output reg  [3:0]  REG_SELECT_OUT,
   output reg         LOW_BYTE_WRITE_ENABLE_OUT,
   output reg         HIGH_BYTE_WRITE_ENABLE_OUT,
   output reg         INTERRUPT_REQUEST_LINE_OUT,
   output reg         ACK_CHAIN_OUT,
   output reg         VECTOR_TO_BUS_OUT,
   output reg         VECTOR_BIT_TWO_OUT,
   output reg  [8:0]  VECTOR_DATA_OUT,
   output reg         VECTOR_DATA_OE_OUT,
   output reg         SOFTWARE_MASTER_CLEAR_OUT,
   output reg         MODEM_CLEAR_OUT,
   output reg  [3:0]  DTR_OUT
);

   // =======================================================================
   // Helpers
   // =======================================================================
   function [3:0] bsi_onehot;
      input [1:0] idx;
      begin
         bsi_onehot = 4'h1 << idx;
      end
   endfunction

   function bsi_field;
      input [31:0] word;
      input integer pos;
      begin
         bsi_field = word[pos];
      end
   endfunction

   // =======================================================================
   // State
   // =======================================================================
   // Host-bus inputs are taken as already synchronous to the core clock.
   // Every response to the host therefore lags its cause by at least one edge, which
   // the host tolerates because it waits on the reply level, not on time.
   reg                  sync_q;
   reg                  match_q;
   reg [2:0]            addr_q;
   reg                  receive_irq_enable;
   reg                  fifo_alarm_enable;
   reg                  transmit_irq_enable;
   reg [`BSI_CNT_W-1:0] mclr_cnt;
   reg [`BSI_CNT_W-1:0] ext_cnt;

   reg                  next_sync_q;
   reg                  next_match_q;
   reg [2:0]            next_addr_q;
   reg                  next_rie;
   reg                  next_sae;
   reg                  next_tie;
   reg [`BSI_CNT_W-1:0] next_mclr_cnt;
   reg [`BSI_CNT_W-1:0] next_ext_cnt;
   reg [31:0]           next_readdata;
   reg                  next_wait;
   reg                  next_reply;
   reg [3:0]            next_select;
   reg                  next_low_we;
   reg                  next_high_we;
   reg                  next_irq;
   reg                  next_ack_out;
   reg                  next_vtb;
   reg                  next_vbit2;
   reg [8:0]            next_vec;
   reg                  next_vec_oe;
   reg                  next_sw_clr;
   reg                  next_modem_clr;
   reg [3:0]            next_dtr;

   reg                  clr_any;
   reg                  readback_clr;
   reg                  rx_cond;
   reg                  tx_cond;
   reg                  wr_cycle;
   reg                  sel_live;
   reg                  av_req;
   reg                  av_wr;
   reg [31:0]           ctrl_word;

   // =======================================================================
   // Next-state logic
   // =======================================================================
   always @*
   begin
      next_sync_q    = CYCLE_SYNC_IN;
      next_match_q   = match_q;
      next_addr_q    = addr_q;
      next_rie       = receive_irq_enable;
      next_sae       = fifo_alarm_enable;
      next_tie       = transmit_irq_enable;
      next_mclr_cnt  = mclr_cnt;
      next_ext_cnt   = ext_cnt;
      next_readdata  = AVS_READDATA_OUT;
      next_wait      = 1'b1;
      next_dtr       = DTR_OUT;
      next_vtb       = VECTOR_TO_BUS_OUT;
      next_vbit2     = VECTOR_BIT_TWO_OUT;
      next_ack_out   = 1'b0;
      next_modem_clr = BUS_INITIALIZE_IN;

      // Address bits and match are caught on the leading edge of sync.
      if (CYCLE_SYNC_IN && !sync_q)
      begin
         next_match_q = ADDRESS_MATCH_IN;
         next_addr_q  = ADDRESS_LOW_IN;
      end

      // -------------------------------------------------------------------
      // Initialization
      // -------------------------------------------------------------------
      clr_any      = SOFTWARE_MASTER_CLEAR_OUT | BUS_INITIALIZE_IN;
      readback_clr = clr_any | (ext_cnt != {`BSI_CNT_W{1'b0}});
      if (mclr_cnt != {`BSI_CNT_W{1'b0}})
      begin
         next_mclr_cnt = mclr_cnt - 1'b1;
      end
      // The stretch restarts every cycle a clear is active, so read-back
      // outlasts whichever clear source ended last.
      if (clr_any)
      begin
         next_ext_cnt = `BSI_EXT_CYC;
      end
      else if (ext_cnt != {`BSI_CNT_W{1'b0}})
      begin
         next_ext_cnt = ext_cnt - 1'b1;
      end
      if (BUS_INITIALIZE_IN)
      begin
         next_dtr = `BSI_RST_DTR;
      end

      // -------------------------------------------------------------------
      // Interrupt conditions
      // -------------------------------------------------------------------
      rx_cond = receive_irq_enable & ~clr_any & (fifo_alarm_enable ? SILO_ALARM_IN : RX_DONE_IN);
      tx_cond = transmit_irq_enable & ~clr_any & TX_READY_IN;

      // -------------------------------------------------------------------
      // Vector transaction
      // -------------------------------------------------------------------
      // The grant is decided in one cycle from the live conditions, so the
      // receiver always wins when both channels ask at the same edge.
      // Dropping the vector waits only on the read strobe; the acknowledge
      // may linger a cycle longer without reopening the transaction.
      if (VECTOR_TO_BUS_OUT)
      begin
         if (!READ_DATA_STROBE_IN)
         begin
            next_vtb   = 1'b0;
            next_vbit2 = 1'b0;
         end
      end
      else if (READ_DATA_STROBE_IN && ACK_CHAIN_IN && !ACK_CHAIN_OUT)
      begin
         if (rx_cond)
         begin
            next_vtb   = 1'b1;
            next_vbit2 = 1'b0;
         end
         else if (tx_cond)
         begin
            next_vtb   = 1'b1;
            next_vbit2 = 1'b1;
         end
      end

      // Once the acknowledge is passed on it stays passed on for the rest of
      // that acknowledge, so a late condition cannot steal a grant midway.
      if (ACK_CHAIN_IN && !VECTOR_TO_BUS_OUT && !next_vtb)
      begin
         next_ack_out = ACK_CHAIN_OUT | ~(rx_cond | tx_cond);
      end

      next_irq    = (rx_cond | tx_cond) & ~next_vtb;
      next_vec    = next_vtb ? {VECTOR_SWITCH_IN, next_vbit2, 2'b00} : 9'h000;
      next_vec_oe = next_vtb;

      // -------------------------------------------------------------------
      // Host write cycle front end
      // -------------------------------------------------------------------
      // Select waits one cycle after sync so that the latched address is
      // settled before any register line is raised.
      sel_live = CYCLE_SYNC_IN & sync_q & match_q;
      wr_cycle = sel_live & WRITE_DATA_STROBE_IN;
      next_select  = sel_live ? bsi_onehot(addr_q[2:1]) : 4'h0;
      next_low_we  = wr_cycle & (~BYTE_WRITE_QUALIFIER_IN | ~addr_q[0]);
      next_high_we = wr_cycle & (~BYTE_WRITE_QUALIFIER_IN | addr_q[0]);
      next_reply   = next_vtb | wr_cycle;

      // -------------------------------------------------------------------
      // Avalon-MM register access
      // -------------------------------------------------------------------
      // Each access costs two cycles: one to register the answer and one in
      // which waitrequest is low. A write lands only in that second cycle.
      ctrl_word                  = `BSI_RST_WORD;
      ctrl_word[`BSI_BIT_MCLR]   = readback_clr;
      ctrl_word[`BSI_BIT_RIE]    = receive_irq_enable;
      ctrl_word[`BSI_BIT_RXDONE] = RX_DONE_IN & ~fifo_alarm_enable;
      ctrl_word[`BSI_BIT_SAE]    = fifo_alarm_enable;
      ctrl_word[`BSI_BIT_TIE]    = transmit_irq_enable;
      ctrl_word[`BSI_BIT_TXRDY]  = TX_READY_IN;

      av_req = AVS_READ_IN | AVS_WRITE_IN;
      av_wr  = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
      if (av_req && AVS_WAITREQUEST_OUT)
      begin
         next_wait = 1'b0;
         case (AVS_ADDRESS_IN)
            `BSI_OFF_CTRL:
               next_readdata = ctrl_word;
            `BSI_OFF_MODEM:
               next_readdata = {28'h0000000, DTR_OUT};
            `BSI_OFF_IRQST:
               next_readdata = {27'h0000000, VECTOR_BIT_TWO_OUT,
                                VECTOR_TO_BUS_OUT, INTERRUPT_REQUEST_LINE_OUT,
                                tx_cond, rx_cond};
            default:
               next_readdata = `BSI_RST_WORD;
         endcase
      end

      if (av_wr && AVS_ADDRESS_IN == `BSI_OFF_CTRL)
      begin
         if (AVS_BYTEENABLE_IN[0])
         begin
            next_rie = bsi_field(AVS_WRITEDATA_IN, `BSI_BIT_RIE);
            if (bsi_field(AVS_WRITEDATA_IN, `BSI_BIT_MCLR))
            begin
               next_mclr_cnt = `BSI_MCLR_CYC;
            end
         end
         if (AVS_BYTEENABLE_IN[1])
         begin
            next_sae = bsi_field(AVS_WRITEDATA_IN, `BSI_BIT_SAE);
            next_tie = bsi_field(AVS_WRITEDATA_IN, `BSI_BIT_TIE);
         end
      end
      if (av_wr && AVS_ADDRESS_IN == `BSI_OFF_MODEM && AVS_BYTEENABLE_IN[0] && !BUS_INITIALIZE_IN)
      begin
         next_dtr = AVS_WRITEDATA_IN[3:0];
      end

      // Either clear source wipes the interrupt enables; a software write in
      // the same cycle loses, since the clear is meant to be absolute.
      if (clr_any)
      begin
         next_rie = 1'b0;
         next_sae = 1'b0;
         next_tie = 1'b0;
      end

      next_sw_clr = (next_mclr_cnt != {`BSI_CNT_W{1'b0}});
   end

   // =======================================================================
   // Registers
   // =======================================================================
   always @(posedge CORE_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         sync_q                     <= 1'b0;
         match_q                    <= 1'b0;
         addr_q                     <= 3'h0;
         receive_irq_enable                        <= 1'b0;
         fifo_alarm_enable                        <= 1'b0;
         transmit_irq_enable                        <= 1'b0;
         mclr_cnt                   <= {`BSI_CNT_W{1'b0}};
         ext_cnt                    <= {`BSI_CNT_W{1'b0}};
         AVS_READDATA_OUT           <= `BSI_RST_WORD;
         AVS_WAITREQUEST_OUT        <= 1'b1;
         SLAVE_REPLY_OUT            <= 1'b0;
         REG_SELECT_OUT             <= 4'h0;
         LOW_BYTE_WRITE_ENABLE_OUT  <= 1'b0;
         HIGH_BYTE_WRITE_ENABLE_OUT <= 1'b0;
         INTERRUPT_REQUEST_LINE_OUT <= 1'b0;
         ACK_CHAIN_OUT              <= 1'b0;
         VECTOR_TO_BUS_OUT          <= 1'b0;
         VECTOR_BIT_TWO_OUT         <= 1'b0;
         VECTOR_DATA_OUT            <= 9'h000;
         VECTOR_DATA_OE_OUT         <= 1'b0;
         SOFTWARE_MASTER_CLEAR_OUT  <= 1'b0;
         MODEM_CLEAR_OUT            <= 1'b0;
         DTR_OUT                    <= `BSI_RST_DTR;
      end
      else if (CLK_EN_IN)
      begin
         sync_q                     <= next_sync_q;
         match_q                    <= next_match_q;
         addr_q                     <= next_addr_q;
         receive_irq_enable                        <= next_rie;
         fifo_alarm_enable                        <= next_sae;
         transmit_irq_enable                        <= next_tie;
         mclr_cnt                   <= next_mclr_cnt;
         ext_cnt                    <= next_ext_cnt;
         AVS_READDATA_OUT           <= next_readdata;
         AVS_WAITREQUEST_OUT        <= next_wait;
         SLAVE_REPLY_OUT            <= next_reply;
         REG_SELECT_OUT             <= next_select;
         LOW_BYTE_WRITE_ENABLE_OUT  <= next_low_we;
         HIGH_BYTE_WRITE_ENABLE_OUT <= next_high_we;
         INTERRUPT_REQUEST_LINE_OUT <= next_irq;
         ACK_CHAIN_OUT              <= next_ack_out;
         VECTOR_TO_BUS_OUT          <= next_vtb;
         VECTOR_BIT_TWO_OUT         <= next_vbit2;
         VECTOR_DATA_OUT            <= next_vec;
         VECTOR_DATA_OE_OUT         <= next_vec_oe;
         SOFTWARE_MASTER_CLEAR_OUT  <= next_sw_clr;
         MODEM_CLEAR_OUT            <= next_modem_clr;
         DTR_OUT                    <= next_dtr;
      end
   end

endmodule // bsi_top

// ### sim/bsi_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host side of the asynchronous handshake bus
// ==========================================================================
module bsi_host_model
(
   input  wire        clk_in,
   input  wire        reply_in,
   input  wire        vtb_in,
   input  wire        v2_in,
   input  wire [8:0]  vec_in,
   input  wire        lo_in,
   input  wire        hi_in,
   output logic       sync_out,
   output logic       wstb_out,
   output logic       rstb_out,
   output logic       bwq_out,
   output logic       match_out,
   output logic [2:0] addr_out,
   output logic       ack_out
);
   initial
   begin
      {sync_out, wstb_out, rstb_out, bwq_out, match_out, ack_out} = 6'h00;
      addr_out = 3'h5;
   end

   task automatic write_cycle(input logic q, input logic [2:0] a, output logic lo, output logic hi);
      int n;
      begin
         n = 0;
         @(posedge clk_in);
         match_out <= 1'b1;
         addr_out <= a;
         bwq_out <= q;
         sync_out <= 1'b1;
         repeat (2) @(posedge clk_in);
         wstb_out <= 1'b1;
         do @(posedge clk_in); while (reply_in !== 1'b1 && ++n < 20);
         lo = lo_in;
         hi = hi_in;
         wstb_out <= 1'b0;
         do @(posedge clk_in); while (reply_in !== 1'b0 && ++n < 40);
         sync_out <= 1'b0;
         bwq_out <= 1'b0;
         match_out <= 1'b0;
         // Released address lines show the inverse so stale values are never mistaken for live ones.
         addr_out <= ~a;
      end
   endtask

   task automatic int_ack(output logic v2, output logic [8:0] vec, output logic seen);
      int n;
      begin
         n = 0;
         @(posedge clk_in);
         rstb_out <= 1'b1;
         @(posedge clk_in);
         ack_out <= 1'b1;
         do @(posedge clk_in); while (vtb_in !== 1'b1 && ++n < 20);
         seen = reply_in & vtb_in;
         v2 = v2_in;
         vec = vec_in;
         rstb_out <= 1'b0;
         @(posedge clk_in);
         ack_out <= 1'b0;
      end
   endtask
endmodule // bsi_host_model

// ### sim/bsi_top_assertions.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker
// ==========================================================================
module bsi_checker
(
   input wire        CORE_CLK_IN,
   input wire        SYS_RST_IN,
   input wire [3:0]  AVS_ADDRESS_IN,
   input wire        AVS_WRITE_IN,
   input wire [31:0] AVS_WRITEDATA_IN,
   input wire        AVS_WAITREQUEST_OUT,
   input wire        CYCLE_SYNC_IN,
   input wire        WRITE_DATA_STROBE_IN,
   input wire        READ_DATA_STROBE_IN,
   input wire        BYTE_WRITE_QUALIFIER_IN,
   input wire        ADDRESS_MATCH_IN,
   input wire        BUS_INITIALIZE_IN,
   input wire        ACK_CHAIN_IN,
   input wire        ACK_CHAIN_OUT,
   input wire [5:0]  VECTOR_SWITCH_IN,
   input wire        SLAVE_REPLY_OUT,
   input wire [3:0]  REG_SELECT_OUT,
   input wire        LOW_BYTE_WRITE_ENABLE_OUT,
   input wire        HIGH_BYTE_WRITE_ENABLE_OUT,
   input wire        INTERRUPT_REQUEST_LINE_OUT,
   input wire        VECTOR_TO_BUS_OUT,
   input wire        VECTOR_BIT_TWO_OUT,
   input wire [8:0]  VECTOR_DATA_OUT,
   input wire        VECTOR_DATA_OE_OUT,
   input wire        SOFTWARE_MASTER_CLEAR_OUT,
   input wire        MODEM_CLEAR_OUT,
   input wire [3:0]  DTR_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   reply_drop_a: assert property (
      $fell(WRITE_DATA_STROBE_IN) && !VECTOR_TO_BUS_OUT |-> ##[1:2] !SLAVE_REPLY_OUT) else $error("reply held");
   reply_raise_a: assert property (
      $rose(WRITE_DATA_STROBE_IN) && CYCLE_SYNC_IN && ADDRESS_MATCH_IN |-> ##[1:2] SLAVE_REPLY_OUT)
      else $error("no write reply");
   select_free_a: assert property (
      $fell(CYCLE_SYNC_IN) |-> ##[1:2] (REG_SELECT_OUT == 4'h0 && !LOW_BYTE_WRITE_ENABLE_OUT
      && !HIGH_BYTE_WRITE_ENABLE_OUT)) else $error("select held");
   byte_lane_a: assert property (
      LOW_BYTE_WRITE_ENABLE_OUT || HIGH_BYTE_WRITE_ENABLE_OUT |->
      ((LOW_BYTE_WRITE_ENABLE_OUT && HIGH_BYTE_WRITE_ENABLE_OUT) == !BYTE_WRITE_QUALIFIER_IN))
      else $error("wrong lanes");
   vector_drive_a: assert property (
      VECTOR_TO_BUS_OUT |-> SLAVE_REPLY_OUT && VECTOR_DATA_OE_OUT
      && VECTOR_DATA_OUT == {VECTOR_SWITCH_IN, VECTOR_BIT_TWO_OUT, 2'b00}) else $error("bad vector");
   irq_drop_a: assert property (
      $rose(VECTOR_TO_BUS_OUT) |-> !INTERRUPT_REQUEST_LINE_OUT) else $error("request kept");
   vector_release_a: assert property (
      $fell(READ_DATA_STROBE_IN) |-> ##[1:2] (!VECTOR_TO_BUS_OUT && !VECTOR_BIT_TWO_OUT && !VECTOR_DATA_OE_OUT))
      else $error("vector kept");
   clear_start_a: assert property (
      AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0 && AVS_WRITEDATA_IN[4]
      |-> ##[1:2] SOFTWARE_MASTER_CLEAR_OUT) else $error("no clear pulse");
   modem_clear_a: assert property (
      BUS_INITIALIZE_IN |=> MODEM_CLEAR_OUT) else $error("no modem clear");
   ack_pass_a: assert property (
      $rose(ACK_CHAIN_IN) && !INTERRUPT_REQUEST_LINE_OUT && !VECTOR_TO_BUS_OUT |-> ##[1:2] ACK_CHAIN_OUT)
      else $error("acknowledge not passed");
   dtr_clear_a: assert property (
      MODEM_CLEAR_OUT |-> ##[0:1] DTR_OUT == 4'h0) else $error("ready bits kept");
endmodule // bsi_checker

bind bsi_top bsi_checker u_chk (.CORE_CLK_IN, .SYS_RST_IN, .AVS_ADDRESS_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
   .AVS_WAITREQUEST_OUT, .CYCLE_SYNC_IN, .WRITE_DATA_STROBE_IN, .READ_DATA_STROBE_IN, .BYTE_WRITE_QUALIFIER_IN,
   .ADDRESS_MATCH_IN, .BUS_INITIALIZE_IN, .ACK_CHAIN_IN, .ACK_CHAIN_OUT, .VECTOR_SWITCH_IN, .SLAVE_REPLY_OUT,
   .REG_SELECT_OUT,
   .LOW_BYTE_WRITE_ENABLE_OUT, .HIGH_BYTE_WRITE_ENABLE_OUT, .INTERRUPT_REQUEST_LINE_OUT, .VECTOR_TO_BUS_OUT,
   .VECTOR_BIT_TWO_OUT, .VECTOR_DATA_OUT, .VECTOR_DATA_OE_OUT, .SOFTWARE_MASTER_CLEAR_OUT, .MODEM_CLEAR_OUT,
   .DTR_OUT);

// ### sim/tb_bsi_top.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench for the bus slave front end
// ==========================================================================
module tb_bsi_top;
   localparam logic [5:0] SW = 6'h2D;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic        init = 1'b0;
   logic        rxd = 1'b0;
   logic        silo = 1'b0;
   logic        txr = 1'b0;
   wire  [31:0] rdat;
   wire  [2:0]  alow;
   wire  [8:0]  vec;
   wire  [3:0]  dtr;
   wire         wreq, sync, wstb, rstb, bwq, match, ack, reply, lo, hi, irq, vtb, v2, swclr, mclr;
   int          err_total = 0;
   int          check_count = 0;

   always #4 clk = ~clk;

   bsi_top dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat),
      .AVS_WAITREQUEST_OUT(wreq), .CYCLE_SYNC_IN(sync), .WRITE_DATA_STROBE_IN(wstb), .READ_DATA_STROBE_IN(rstb),
      .BYTE_WRITE_QUALIFIER_IN(bwq), .ADDRESS_MATCH_IN(match), .ADDRESS_LOW_IN(alow), .ACK_CHAIN_IN(ack),
      .BUS_INITIALIZE_IN(init), .RX_DONE_IN(rxd), .SILO_ALARM_IN(silo), .TX_READY_IN(txr), .VECTOR_SWITCH_IN(SW),
      .SLAVE_REPLY_OUT(reply), .REG_SELECT_OUT(), .LOW_BYTE_WRITE_ENABLE_OUT(lo), .HIGH_BYTE_WRITE_ENABLE_OUT(hi),
      .INTERRUPT_REQUEST_LINE_OUT(irq), .ACK_CHAIN_OUT(), .VECTOR_TO_BUS_OUT(vtb), .VECTOR_BIT_TWO_OUT(v2),
      .VECTOR_DATA_OUT(vec), .VECTOR_DATA_OE_OUT(), .SOFTWARE_MASTER_CLEAR_OUT(swclr), .MODEM_CLEAR_OUT(mclr),
      .DTR_OUT(dtr));

   bsi_host_model host (.clk_in(clk), .reply_in(reply), .vtb_in(vtb), .v2_in(v2), .vec_in(vec), .lo_in(lo),
      .hi_in(hi), .sync_out(sync), .wstb_out(wstb), .rstb_out(rstb), .bwq_out(bwq), .match_out(match),
      .addr_out(alow), .ack_out(ack));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic t_write;
      logic l, h;
      for (int i = 0; i < 3; i++)
      begin
         host.write_cycle(i != 0, {2'b10, i == 2}, l, h);
         chk("low lane", i != 2, l);
         chk("high lane", i != 1, h);
      end
      $display("test write lanes done");
   endtask

   task automatic t_irq;
      logic b, s;
      logic [8:0]  v;
      logic [31:0] q;
      avs(1'b1, 4'h0, 32'h0000_4040, q);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("enables", 32'h4040, q & 32'h5050);
      rxd <= 1'b1;
      txr <= 1'b1;
      repeat (4) @(posedge clk);
      chk("irq", 1'b1, irq);
      host.int_ack(b, v, s);
      chk("reply", 1'b1, s);
      chk("vector rx", {SW, 3'b000}, v);
      rxd <= 1'b0;
      repeat (4) @(posedge clk);
      host.int_ack(b, v, s);
      chk("vector tx", {SW, 3'b100}, v);
      chk("bit two", 1'b1, b);
      repeat (3) @(posedge clk);
      chk("irq again", 1'b1, irq);
      txr <= 1'b0;
      rxd <= 1'b1;
      avs(1'b1, 4'h0, 32'h0000_1040, q);
      repeat (4) @(posedge clk);
      chk("alarm gate", 1'b0, irq);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("done bit", 1'b0, q[7]);
      silo <= 1'b1;
      repeat (4) @(posedge clk);
      chk("alarm irq", 1'b1, irq);
      host.int_ack(b, v, s);
      chk("vector alarm", {SW, 3'b000}, v);
      silo <= 1'b0;
      rxd <= 1'b0;
      $display("test interrupts done");
   endtask

   task automatic t_clear;
      logic [31:0] q;
      avs(1'b1, 4'h4, 32'h0000_000F, q);
      // Enables written together with the clear bit must lose to the clear.
      avs(1'b1, 4'h0, 32'h0000_4050, q);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("clear busy", 1'b1, q[4]);
      chk("enables cleared", 32'h0, q & 32'h5040);
      chk("dtr kept", 4'hF, dtr);
      repeat (310) @(posedge clk);
      chk("pulse end", 1'b0, swclr);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("readback tail", 1'b1, q[4]);
      repeat (40) @(posedge clk);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("clear done", 1'b0, q[4]);
      avs(1'b1, 4'h0, 32'h0000_4040, q);
      init <= 1'b1;
      repeat (4) @(posedge clk);
      chk("modem clear", 1'b1, mclr);
      chk("dtr cleared", 4'h0, dtr);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("init busy", 1'b1, q[4]);
      init <= 1'b0;
      repeat (45) @(posedge clk);
      avs(1'b0, 4'h0, 32'h0, q);
      chk("init enables", 32'h0, q & 32'h5050);
      avs(1'b0, 4'hC, 32'h0, q);
      chk("unmapped", 32'h0, q);
      $display("test clears done");
   endtask

   task automatic t_pass;
      logic b, s;
      logic [8:0] v;
      host.int_ack(b, v, s);
      chk("pass reply", 1'b0, s);
      chk("pass vector", 9'h000, v);
      $display("test acknowledge pass done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_write();
      t_irq();
      t_clear();
      t_pass();
      finish_test();
   end

   // The run needs under two thousand cycles, so this limit only trips on a hung handshake.
   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      $display("mismatch watchdog expected finish seen hang");
      finish_test();
   end
endmodule // tb_bsi_top
